/* File: shared/drd_pkg.sv */
// constants, types and helpers shared by both ends
// assumes little-endian multi-byte image fields
package drd_pkg;
	localparam int OUT_BYTES = 40; // output image length
	localparam int IN_BYTES = 44; // input image length
	localparam logic [7:0] OUT_INSTANCE = 8'h67; // output image 103
	localparam logic [7:0] IN_INSTANCE = 8'h71; // input image 113
	// output image byte offsets
	localparam int OB_PARAM = 0;
	localparam int OB_REF32 = 8;
	localparam int OB_REF16 = 12;
	localparam int OB_MODE = 14;
	localparam int OB_STATE = 15;
	localparam int OB_ACC = 16;
	localparam int OB_DEC = 20;
	// input image byte offsets
	localparam int IB_PARAM = 0;
	localparam int IB_ACTION = 14;
	localparam int IB_MSTAT = 17;
	localparam int IB_DSTATE = 18;
	// mode control byte fields
	localparam int MC_CODE_LSB = 0;
	localparam int MC_ACT_LSB = 4;
	localparam int MC_HS_BIT = 7;
	// mode status byte fields
	localparam int MS_HOMED_BIT = 5;
	localparam int MS_REJECT_BIT = 6;
	// explicit address of the action status word: 128.1.4
	localparam logic [7:0] AS_CLASS = 8'h80;
	localparam logic [7:0] AS_INSTANCE = 8'h01;
	localparam logic [7:0] AS_ATTRIBUTE = 8'h04;
	// action status word bit positions
	localparam int AS_WARN = 0;
	localparam int AS_ERR_LSB = 1;
	localparam int AS_STILL = 6;
	localparam int AS_CW = 7;
	localparam int AS_CCW = 8;
	localparam int AS_IDLE = 11;
	localparam int AS_DECEL = 12;
	localparam int AS_CONST = 13;
	// state control byte bits (word bits 8..15 -> 0..7)
	localparam int SC_DIS = 0;
	localparam int SC_EN = 1;
	localparam int SC_QS = 2;
	localparam int SC_FR = 3;
	localparam int SC_HALT = 5;
	localparam int SC_CLR = 6;
	localparam int SC_RES = 7;
	// operating mode codes
	typedef enum logic [3:0] {
		DRD_NONE = 4'b0000,
		DRD_JOG = 4'b0001,
		DRD_HOMING = 4'b0010,
		DRD_PROFPOS = 4'b0011,
		DRD_PROFVEL = 4'b0100,
		DRD_SPEED = 4'b0111
	} drd_mode_e;
	// pickers over an image, byte n at bits 8n+7..8n
	function automatic logic [7:0] drd_byte(input logic [351:0] img, input int b);
		drd_byte = img[8*b +: 8];
	endfunction : drd_byte
	function automatic logic [15:0] drd_word(input logic [351:0] img, input int b);
		drd_word = img[8*b +: 16];
	endfunction : drd_word
	function automatic logic [31:0] drd_dword(input logic [351:0] img, input int b);
		drd_dword = img[8*b +: 32];
	endfunction : drd_dword
	// true for the mode control values the drive processes
	function automatic logic drd_code_ok(input logic [6:0] v);
		case (v)
			7'h01, 7'h02, 7'h12, 7'h03, 7'h13, 7'h23, 7'h04, 7'h17: drd_code_ok = 1'b1;
			default: drd_code_ok = 1'b0;
		endcase
	endfunction : drd_code_ok
endpackage : drd_pkg

/* File: shared/drd_link_if.sv */
// wires between the polling master and the drive
// assumes both ends share clock and reset; the bench joins them
interface drd_link_if;
	logic poll_cmd; // master: poll command strobe
	logic [7:0] poll_instance; // master: output image instance
	logic [319:0] out_image; // master: output image
	logic poll_resp; // drive: poll response strobe
	logic [7:0] resp_instance; // drive: input image instance
	logic [351:0] in_image; // drive: input image
	logic msg_req; // master: explicit request strobe
	logic msg_write; // master: request is a write
	logic [7:0] msg_class; // master: class
	logic [7:0] msg_instance; // master: instance
	logic [7:0] msg_attribute; // master: attribute
	logic msg_resp; // drive: explicit response strobe
	logic [15:0] msg_data; // drive: read data
	logic msg_error; // drive: request refused
	modport drive (
		input poll_cmd, poll_instance, out_image, msg_req, msg_write,
		input msg_class, msg_instance, msg_attribute,
		output poll_resp, resp_instance, in_image, msg_resp, msg_data, msg_error
	);
	modport master (
		output poll_cmd, poll_instance, out_image, msg_req, msg_write,
		output msg_class, msg_instance, msg_attribute,
		input poll_resp, resp_instance, in_image, msg_resp, msg_data, msg_error
	);
endinterface : drd_link_if

/* File: verilog/drd_edge_det.sv */
// rising-edge finder over a vector sampled on a strobe
// assumes strobe marks one received transfer
module drd_edge_det
	import drd_pkg::*;
#(
	parameter int W = 8
)
(
	input wire logic clock,
	input wire logic rstn,
	input wire logic ce,
	input wire logic strobe,
	input wire logic [W-1:0] value,
	output logic [W-1:0] rise
);
	logic [W-1:0] prev; // value of the last transfer
	// remember the last sampled value
	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
			prev <= '0;
		else if (ce && strobe)
			prev <= value;
	end
	// bits that went from 0 to 1 in this transfer
	assign rise = (strobe && ce) ? (value & ~prev) : '0;
endmodule : drd_edge_det

/* File: verilog/drd_drive.sv */
// drive end: decodes each poll and answers with the input image
// assumes a rule-keeping master and synchronous status levels
// What this block does
// - one parameter per explicit request and answer
// - status word lives at 128.1.4, read-only
// - bit 0 warning, bits 1-4 error classes
// - motion and profile flags in bits 6-13
// - cyclic data gets no per-transfer acknowledgement
// - act on power, stop, reset, mode requests
// - state changes and mode starts come separately
// - a different mode starts only at standstill
// - poll 103 answered by response 113
// - split output image into its fields
// - mode byte: code, action, handshake bit
// - mode codes 1,2,3,4,7 decoded
// - homing and positioning action values
// - profile position takes velocity and position
// - jog, profile velocity, speed control values
// - all-zero mode byte ignored, no error
// - evaluate mode only when handshake toggled
// - toggle is either change of the bit
// - master writes refs, mode, then inverts toggle
// - state byte acts on rising edges; all-zero byte disables on every poll
// - unprocessable mode rejected, flag set
module drd_drive
	import drd_pkg::*;
(
	input wire logic clock,
	input wire logic rstn,
	input wire logic ce,
	drd_link_if.drive link,
	input wire logic warning, // warning active
	input wire logic [3:0] error_class, // error classes 1..4 active
	input wire logic at_standstill, // motor at standstill
	input wire logic rot_cw, // rotating clockwise
	input wire logic rot_ccw, // rotating counter-clockwise
	input wire logic prof_idle, // profile generator idle
	input wire logic prof_decel, // profile generator decelerating
	input wire logic prof_const, // profile generator at constant speed
	input wire logic op_enabled, // operating state is operation enabled
	input wire logic homing_done, // homing completed
	input wire logic [15:0] drive_state, // state word returned to the master
	output logic mode_start, // pulse: start accepted mode
	output logic [3:0] mode_code, // mode of the last accepted request
	output logic [2:0] mode_action, // action of the last accepted request
	output logic [31:0] home_position_value, // wide reference
	output logic [15:0] profile_target_velocity, // narrow reference
	output logic [31:0] acceleration_ramp, // acceleration from the image
	output logic [31:0] deceleration_ramp, // deceleration from the image
	output logic [63:0] param_channel, // parameter channel bytes 0..7
	output logic cmd_disable, // pulse: disable power stage
	output logic cmd_enable, // pulse: enable power stage
	output logic cmd_quick_stop, // pulse: quick stop
	output logic cmd_fault_reset, // pulse: fault reset
	output logic cmd_halt, // pulse: halt
	output logic cmd_clear_halt, // pulse: clear halt
	output logic cmd_resume, // pulse: resume after halt
	output logic mode_reject_flag // last mode request was rejected
);
	// all registered state of the drive end except u_state_edges
	typedef struct packed {
		logic prev_hs; // handshake bit of the last transfer
		logic stat_hs; // handshake bit echoed in mode status
		logic reject; // mode reject flag
		logic start; // mode start pulse
		logic [3:0] code; // accepted mode code
		logic [2:0] action; // accepted action
		logic [31:0] ref32; // wide reference
		logic [15:0] ref16; // narrow reference
		logic [31:0] acc; // acceleration ramp
		logic [31:0] dec; // deceleration ramp
		logic [63:0] param; // parameter channel
		logic [6:0] cmds; // state command pulses
		logic presp; // poll response strobe
		logic [7:0] rinst; // response instance
		logic [351:0] img; // input image
		logic mresp; // explicit response strobe
		logic [15:0] mdata; // explicit read data
		logic merr; // explicit error
	} drd_drive_s;

	drd_drive_s st; // current state
	drd_drive_s next_st; // next state
	logic poll_ok; // a poll for the output image arrived
	logic [7:0] mode_byte; // received mode control byte
	logic [7:0] state_byte; // received state control byte
	logic [7:0] sc_rise; // rising edges in the state control byte
	logic [15:0] action_status_value; // live action status word
	logic [7:0] mode_status_byte; // mode status returned to the master

	// only instance 103 counts as a cyclic transfer
	assign poll_ok = link.poll_cmd && (link.poll_instance == OUT_INSTANCE);
	assign mode_byte = drd_byte({32'h0, link.out_image}, OB_MODE);
	assign state_byte = drd_byte({32'h0, link.out_image}, OB_STATE);

	// state control edges against the last transfer
	drd_edge_det #(
		.W(8)
	) u_state_edges (
		.clock(clock),
		.rstn(rstn),
		.ce(ce),
		.strobe(poll_ok),
		.value(state_byte),
		.rise(sc_rise)
	);

	// action status word from the status levels
	always_comb
	begin
		action_status_value = 16'h0000; // reserved bits read zero
		action_status_value[AS_WARN] = warning;
		action_status_value[AS_ERR_LSB +: 4] = error_class;
		action_status_value[AS_STILL] = at_standstill;
		action_status_value[AS_CW] = rot_cw;
		action_status_value[AS_CCW] = rot_ccw;
		action_status_value[AS_IDLE] = prof_idle;
		action_status_value[AS_DECEL] = prof_decel;
		action_status_value[AS_CONST] = prof_const;
	end

	// next state: cyclic decode, mode handshake, explicit answers
	always_comb
	begin
		next_st = st;
		mode_status_byte = 8'h00;
		next_st.start = 1'b0; // start is one cycle only
		next_st.cmds = 7'h00; // commands are one cycle only
		next_st.presp = 1'b0;
		next_st.mresp = 1'b0;
		if (poll_ok)
		begin
			// plain fields each transfer, nothing acknowledged
			next_st.param = link.out_image[8*OB_PARAM +: 64];
			next_st.acc = drd_dword({32'h0, link.out_image}, OB_ACC);
			next_st.dec = drd_dword({32'h0, link.out_image}, OB_DEC);
			next_st.prev_hs = mode_byte[MC_HS_BIT];
			// state commands on rising edges, with precedence; an all-zero byte gives disable on every transfer
			next_st.cmds[0] = sc_rise[SC_DIS] || (state_byte == 8'h00);
			next_st.cmds[1] = sc_rise[SC_EN] && !sc_rise[SC_DIS];
			next_st.cmds[2] = sc_rise[SC_QS];
			next_st.cmds[3] = sc_rise[SC_FR] && !sc_rise[SC_QS];
			next_st.cmds[4] = sc_rise[SC_HALT];
			next_st.cmds[5] = sc_rise[SC_CLR] && !sc_rise[SC_HALT];
			next_st.cmds[6] = sc_rise[SC_RES] && !sc_rise[SC_HALT];
			// mode data only on a handshake change
			if (mode_byte[MC_HS_BIT] != st.prev_hs)
			begin
				next_st.stat_hs = mode_byte[MC_HS_BIT];
				if (mode_byte == 8'h00)
				begin
					// all-zero byte: nothing processed, no error
				end
				else if (!drd_code_ok(mode_byte[6:0]) || !op_enabled ||
					(!at_standstill && (mode_byte[3:0] != st.code)))
				begin
					// refuse, running process untouched
					next_st.reject = 1'b1;
				end
				else
				begin
					// accepted: code, action and both references
					next_st.reject = 1'b0;
					next_st.start = 1'b1;
					next_st.code = mode_byte[MC_CODE_LSB +: 4];
					next_st.action = mode_byte[MC_ACT_LSB +: 3];
					next_st.ref32 = drd_dword({32'h0, link.out_image}, OB_REF32);
					next_st.ref16 = drd_word({32'h0, link.out_image}, OB_REF16);
				end
			end
			// mode status: handshake echo, reject flag, homed, current mode
			mode_status_byte[MC_HS_BIT] = next_st.stat_hs;
			mode_status_byte[MS_REJECT_BIT] = next_st.reject;
			mode_status_byte[MS_HOMED_BIT] = homing_done;
			mode_status_byte[3:0] = next_st.code;
			// poll response carries the input image
			next_st.presp = 1'b1;
			next_st.rinst = IN_INSTANCE;
			next_st.img = '0;
			next_st.img[8*IB_PARAM +: 32] = link.out_image[8*OB_PARAM +: 32];
			next_st.img[8*IB_ACTION +: 16] = action_status_value;
			next_st.img[8*IB_MSTAT +: 8] = mode_status_byte;
			next_st.img[8*IB_DSTATE +: 16] = drive_state;
		end
		// explicit message: one parameter, one answer
		if (link.msg_req)
		begin
			next_st.mresp = 1'b1;
			if (!link.msg_write && link.msg_class == AS_CLASS &&
				link.msg_instance == AS_INSTANCE && link.msg_attribute == AS_ATTRIBUTE)
			begin
				next_st.mdata = action_status_value;
				next_st.merr = 1'b0;
			end
			else
			begin
				// unknown address or write to read-only word
				next_st.mdata = 16'h0000;
				next_st.merr = 1'b1;
			end
		end
	end

	// register the whole state; ce low freezes it
	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
			st <= '0;
		else if (ce)
			st <= next_st;
	end

	// outputs straight from the state register
	assign mode_start = st.start;
	assign mode_code = st.code;
	assign mode_action = st.action;
	assign home_position_value = st.ref32;
	assign profile_target_velocity = st.ref16;
	assign acceleration_ramp = st.acc;
	assign deceleration_ramp = st.dec;
	assign param_channel = st.param;
	assign cmd_disable = st.cmds[0];
	assign cmd_enable = st.cmds[1];
	assign cmd_quick_stop = st.cmds[2];
	assign cmd_fault_reset = st.cmds[3];
	assign cmd_halt = st.cmds[4];
	assign cmd_clear_halt = st.cmds[5];
	assign cmd_resume = st.cmds[6];
	assign mode_reject_flag = st.reject;
	assign link.poll_resp = st.presp;
	assign link.resp_instance = st.rinst;
	assign link.in_image = st.img;
	assign link.msg_resp = st.mresp;
	assign link.msg_data = st.mdata;
	assign link.msg_error = st.merr;
endmodule : drd_drive

/* File: verilog/drd_master.sv */
// master end: builds the output image, polls the drive, reads one parameter
// assumes the user splits state changes and mode requests
module drd_master
	import drd_pkg::*;
(
	input wire logic clock,
	input wire logic rstn,
	input wire logic ce,
	drd_link_if.master link,
	input wire logic poll_go, // pulse: send one poll
	input wire logic mode_go, // pulse: request mode with next poll
	input wire logic [3:0] req_mode, // mode code to request
	input wire logic [2:0] req_action, // action to request
	input wire logic [31:0] req_ref32, // wide reference, 0 when unused
	input wire logic [15:0] req_ref16, // narrow reference, 0 when unused
	input wire logic [7:0] req_state, // state control byte
	input wire logic [31:0] req_acc, // acceleration ramp
	input wire logic [31:0] req_dec, // deceleration ramp
	input wire logic rd_go, // pulse: explicit read
	input wire logic [7:0] rd_class, // class to read
	input wire logic [7:0] rd_instance, // instance to read
	input wire logic [7:0] rd_attribute, // attribute to read
	output logic busy, // poll outstanding
	output logic status_valid, // pulse: new input image
	output logic [7:0] mode_status_byte, // returned mode status
	output logic [15:0] action_word, // returned action word
	output logic mode_done, // drive echoed the handshake bit
	output logic rd_valid, // pulse: explicit answer
	output logic [15:0] rd_data, // explicit read data
	output logic rd_error // explicit request refused
);
	// poll sequencer states
	typedef enum logic [0:0] {
		DRM_IDLE = 1'b0,
		DRM_WAIT = 1'b1
	} drd_mst_e;
	// all registered state of the master end
	typedef struct packed {
		drd_mst_e fsm; // poll sequencer
		logic hs; // handshake bit sent
		logic [7:0] mode; // mode control byte sent
		logic [31:0] ref32; // wide reference
		logic [15:0] ref16; // narrow reference
		logic pcmd; // poll strobe
		logic [319:0] img; // output image
		logic mreq; // explicit strobe
		logic [23:0] addr; // class, instance, attribute
		logic sval; // status pulse
		logic [7:0] mstat; // mode status
		logic [15:0] aword; // action word
		logic rval; // read pulse
		logic [15:0] rdata; // read data
		logic rerr; // read error
	} drd_mst_s;

	drd_mst_s st; // current state
	drd_mst_s next_st; // next state

	// next state of the master end
	always_comb
	begin
		next_st = st;
		next_st.pcmd = 1'b0;
		next_st.mreq = 1'b0;
		next_st.sval = 1'b0;
		next_st.rval = 1'b0;
		// refs and code, then the inverted handshake
		if (mode_go)
		begin
			next_st.ref32 = req_ref32;
			next_st.ref16 = req_ref16;
			next_st.hs = !st.hs;
			next_st.mode = {!st.hs, req_action, req_mode};
		end
		case (st.fsm)
			DRM_IDLE:
			begin
				// each exchange opens with a poll of image 103
				if (poll_go)
				begin
					next_st.pcmd = 1'b1;
					next_st.img = '0;
					next_st.img[8*OB_REF32 +: 32] = st.ref32;
					next_st.img[8*OB_REF16 +: 16] = st.ref16;
					next_st.img[8*OB_MODE +: 8] = st.mode;
					next_st.img[8*OB_STATE +: 8] = req_state;
					next_st.img[8*OB_ACC +: 32] = req_acc;
					next_st.img[8*OB_DEC +: 32] = req_dec;
					next_st.fsm = DRM_WAIT;
				end
			end
			DRM_WAIT:
			begin
				// take the response of image 113
				if (link.poll_resp && link.resp_instance == IN_INSTANCE)
				begin
					next_st.sval = 1'b1;
					next_st.mstat = drd_byte(link.in_image, IB_MSTAT);
					next_st.aword = drd_word(link.in_image, IB_ACTION);
					next_st.fsm = DRM_IDLE;
				end
			end
			default: next_st.fsm = DRM_IDLE;
		endcase
		// explicit read of one parameter
		if (rd_go)
		begin
			next_st.mreq = 1'b1;
			next_st.addr = {rd_class, rd_instance, rd_attribute};
		end
		if (link.msg_resp)
		begin
			next_st.rval = 1'b1;
			next_st.rdata = link.msg_data;
			next_st.rerr = link.msg_error;
		end
	end

	// register the whole state; ce low freezes it
	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
			st <= '0;
		else if (ce)
			st <= next_st;
	end

	// outputs from the state register; poll instance and msg_write are constants
	assign link.poll_cmd = st.pcmd;
	assign link.poll_instance = OUT_INSTANCE;
	assign link.out_image = st.img;
	assign link.msg_req = st.mreq;
	assign link.msg_write = 1'b0;
	assign link.msg_class = st.addr[23:16];
	assign link.msg_instance = st.addr[15:8];
	assign link.msg_attribute = st.addr[7:0];
	assign busy = (st.fsm == DRM_WAIT);
	assign status_valid = st.sval;
	assign mode_status_byte = st.mstat;
	assign action_word = st.aword;
	assign mode_done = (st.mstat[MC_HS_BIT] == st.hs);
	assign rd_valid = st.rval;
	assign rd_data = st.rdata;
	assign rd_error = st.rerr;
endmodule : drd_master

/* File: bench/drd_props.sv */
// concurrent checks on the master-drive link
// assumes one clock and ce high; sits beside the link
module drd_props
	import drd_pkg::*;
(
	input wire logic clock,
	input wire logic rstn,
	input wire logic poll_cmd,
	input wire logic [7:0] poll_instance,
	input wire logic [319:0] out_image,
	input wire logic poll_resp,
	input wire logic [7:0] resp_instance,
	input wire logic [351:0] in_image,
	input wire logic msg_req,
	input wire logic msg_write,
	input wire logic [7:0] msg_class,
	input wire logic [7:0] msg_instance,
	input wire logic [7:0] msg_attribute,
	input wire logic msg_resp,
	input wire logic [15:0] msg_data,
	input wire logic msg_error
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rstn);
	// poll of image 103 answered next cycle
	property p_poll_ans;
		poll_cmd && poll_instance == OUT_INSTANCE |=> poll_resp && resp_instance == IN_INSTANCE;
	endproperty
	a_poll_ans: assert property (p_poll_ans) else $error("poll not answered");
	// no response without a poll
	property p_poll_src;
		poll_resp |-> $past(poll_cmd) && $past(poll_instance) == OUT_INSTANCE;
	endproperty
	a_poll_src: assert property (p_poll_src) else $error("stray poll response");
	// parameter channel head comes back as sent
	property p_echo;
		poll_resp |-> in_image[31:0] == $past(out_image[31:0]);
	endproperty
	a_echo: assert property (p_echo) else $error("parameter channel not echoed");
	// unused input bytes stay zero
	property p_tail;
		poll_resp |-> in_image[351:160] == 192'h0 && in_image[135:128] == 8'h0
			&& in_image[111:32] == 80'h0;
	endproperty
	a_tail: assert property (p_tail) else $error("input image filler not zero");
	// reserved status bits stay zero
	property p_rsv;
		poll_resp |-> (in_image[8*IB_ACTION +: 16] & 16'hc620) == 16'h0000;
	endproperty
	a_rsv: assert property (p_rsv) else $error("reserved status bit set");
	// one answer per request, next cycle
	property p_msg_ans;
		msg_req |=> msg_resp;
	endproperty
	a_msg_ans: assert property (p_msg_ans) else $error("explicit request not answered");
	// only a read of the status word is accepted
	property p_msg_err;
		msg_resp |-> msg_error == $past(msg_write || msg_class != AS_CLASS
			|| msg_instance != AS_INSTANCE || msg_attribute != AS_ATTRIBUTE);
	endproperty
	a_msg_err: assert property (p_msg_err) else $error("explicit address decode wrong");
	// a refused request carries no data
	property p_err_data;
		msg_error |-> msg_data == 16'h0000;
	endproperty
	a_err_data: assert property (p_err_data) else $error("data with refusal");
	// answer fields hold between responses
	property p_hold;
		!msg_resp |-> $stable(msg_data) && $stable(msg_error);
	endproperty
	a_hold: assert property (p_hold) else $error("explicit answer changed");
endmodule : drd_props

/* File: bench/tb_drive_cyclic_command_decoder.sv */
// joins master and drive and runs directed sequences
// assumes 10 MHz clock, ce held high, status levels set here
module tb_drive_cyclic_command_decoder
	import drd_pkg::*;
	;
	timeunit 1ns;
	timeprecision 100ps;
	logic clock, rstn, ce, poll_go, mode_go, rd_go, op_enabled, homing_done, hs; // bench drives
	logic [3:0] req_mode;
	logic [2:0] req_action;
	logic [31:0] req_ref32, req_acc, req_dec;
	logic [15:0] req_ref16, drive_state;
	logic [7:0] req_state, rd_class, rd_instance, rd_attribute, seen; // seen gathers cmd pulses
	logic [10:0] st; // packed drive status levels
	logic warning, at_standstill, rot_cw, rot_ccw, prof_idle, prof_decel, prof_const;
	logic [3:0] error_class;
	logic busy, status_valid, mode_done, rd_valid, rd_error, mode_start, mode_reject_flag;
	logic [7:0] mode_status_byte;
	logic [15:0] action_word, rd_data, profile_target_velocity;
	logic [3:0] mode_code;
	logic [2:0] mode_action;
	logic [31:0] home_position_value, acceleration_ramp, deceleration_ramp;
	logic [63:0] param_channel;
	logic cmd_disable, cmd_enable, cmd_quick_stop, cmd_fault_reset, cmd_halt, cmd_clear_halt;
	logic cmd_resume;
	int errors = 0, checks = 0, starts = 0;
	logic [10:0] pats [2] = '{11'h5a5, 11'h25a}; // status patterns and complements
	logic [6:0] codes [8] = '{7'h01, 7'h02, 7'h12, 7'h03, 7'h13, 7'h23, 7'h04, 7'h17};
	logic [6:0] rcodes [3] = '{7'h05, 7'h04, 7'h04}; // bad code, moving, not enabled
	logic [7:0] scur [11] = '{8'h11, 8'h12, 8'h14, 8'h18, 8'h30, 8'h50, 8'h90, 8'h13,
		8'h1c, 8'hf0, 8'h00};
	logic [7:0] sexp [11] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h20, 8'h40, 8'h80, 8'h01,
		8'h04, 8'h20, 8'h01};
	assign {warning, error_class, at_standstill, rot_cw, rot_ccw, prof_idle, prof_decel,
		prof_const} = st;
	drd_link_if link();
	drd_master i_drd_master (.clock, .rstn, .ce, .link, .poll_go, .mode_go, .req_mode,
		.req_action, .req_ref32, .req_ref16, .req_state, .req_acc, .req_dec, .rd_go, .rd_class,
		.rd_instance, .rd_attribute, .busy, .status_valid, .mode_status_byte, .action_word,
		.mode_done, .rd_valid, .rd_data, .rd_error);
	drd_drive i_drd_drive (.clock, .rstn, .ce, .link, .warning, .error_class, .at_standstill,
		.rot_cw, .rot_ccw, .prof_idle, .prof_decel, .prof_const, .op_enabled, .homing_done,
		.drive_state, .mode_start, .mode_code, .mode_action, .home_position_value,
		.profile_target_velocity, .acceleration_ramp, .deceleration_ramp, .param_channel,
		.cmd_disable, .cmd_enable, .cmd_quick_stop, .cmd_fault_reset, .cmd_halt,
		.cmd_clear_halt, .cmd_resume, .mode_reject_flag);
	drd_props i_drd_props (.clock(clock), .rstn(rstn), .poll_cmd(link.poll_cmd),
		.poll_instance(link.poll_instance), .out_image(link.out_image),
		.poll_resp(link.poll_resp), .resp_instance(link.resp_instance),
		.in_image(link.in_image), .msg_req(link.msg_req), .msg_write(link.msg_write),
		.msg_class(link.msg_class), .msg_instance(link.msg_instance),
		.msg_attribute(link.msg_attribute), .msg_resp(link.msg_resp),
		.msg_data(link.msg_data), .msg_error(link.msg_error));
	// free running clock, 100 ns period
	always #50 clock = ~clock;
	// gather pulses in state byte order
	always @(posedge clock)
	begin
		seen = seen | {cmd_resume, cmd_clear_halt, cmd_halt, 1'b0, cmd_fault_reset,
			cmd_quick_stop, cmd_enable, cmd_disable};
		starts = starts + ((mode_start === 1'b1) ? 1 : 0);
	end
	// expected status word
	function automatic logic [15:0] exp_as(input logic [10:0] s);
		exp_as = {2'b00, s[0], s[1], s[2], 2'b00, s[3], s[4], s[5], 1'b0, s[9:6], s[10]};
	endfunction : exp_as
	// compare and count
	task automatic check(input logic [63:0] got, input logic [63:0] exp);
		checks++;
		if (got !== exp)
		begin
			errors++;
			$display("wrong value at %0t: seen %h expected %h", $time, got, exp);
		end
	endtask : check
	// one poll, from falling edge to falling edge
	task automatic poll();
		int n = 0;
		seen = 8'h00;
		starts = 0;
		poll_go = 1'b1;
		@(negedge clock);
		poll_go = 1'b0;
		while (status_valid !== 1'b1 && n < 8)
		begin
			@(negedge clock);
			n++;
		end
		check({busy, n < 8}, 2'b01);
	endtask : poll
	// mode request, carried by the next poll
	task automatic mode_req(input logic [6:0] code, input logic [31:0] r32, input logic [15:0] r16);
		req_mode = code[3:0];
		req_action = code[6:4];
		req_ref32 = r32;
		req_ref16 = r16;
		mode_go = 1'b1;
		@(negedge clock);
		mode_go = 1'b0;
		hs = ~hs;
		poll();
		check(link.out_image[8*OB_MODE +: 8], {hs, code});
		check(link.out_image[8*OB_REF32 +: 48], {r16, r32});
		check({mode_done, mode_status_byte[7]}, {1'b1, hs});
	endtask : mode_req
	// explicit read
	task automatic rd(input logic [7:0] c, input logic [7:0] a, input logic [15:0] d, input logic e);
		int n = 0;
		rd_class = c;
		rd_instance = AS_INSTANCE;
		rd_attribute = a;
		rd_go = 1'b1;
		@(negedge clock);
		rd_go = 1'b0;
		while (rd_valid !== 1'b1 && n < 8)
		begin
			@(negedge clock);
			n++;
		end
		check({n < 8, rd_error, rd_data}, {1'b1, e, d});
	endtask : rd
	// verdict and end of run
	task automatic end_sim();
		if (errors == 0 && checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : end_sim
	// main sequence
	initial
	begin
		{clock, rstn, poll_go, mode_go, rd_go, homing_done, hs, req_mode, req_action} = '0;
		{req_ref32, req_ref16, req_acc, req_dec, req_state, drive_state, st} = '0;
		{rd_class, rd_instance, rd_attribute} = '0;
		ce = 1'b1;
		op_enabled = 1'b1;
		repeat (3) @(negedge clock);
		rstn = 1'b1;
		@(negedge clock);
		check({mode_status_byte, action_word, mode_reject_flag}, 25'h0);
		// status word over both paths
		for (int i = 0; i < 2; i++)
		begin
			st = pats[i];
			drive_state = {5'h00, pats[i]};
			rd(AS_CLASS, AS_ATTRIBUTE, exp_as(pats[i]), 1'b0);
			poll();
			check(action_word, exp_as(pats[i]));
			check(link.in_image[8*IB_DSTATE +: 16], {5'h00, pats[i]});
		end
		rd(AS_CLASS, 8'h05, 16'h0000, 1'b1);
		rd(8'h81, AS_ATTRIBUTE, 16'h0000, 1'b1);
		// every valid mode value, handshake both ways
		st = 11'h020;
		for (int i = 0; i < 8; i++)
		begin
			mode_req(codes[i], 32'h1000_0000 + i, 16'h0100 + 16'(i));
			check(starts, 1);
			check({mode_action, mode_code}, codes[i]);
			check({profile_target_velocity, home_position_value},
				{16'h0100 + 16'(i), 32'h1000_0000 + i});
			check(mode_status_byte[6:0], {3'b000, codes[i][3:0]});
		end
		// refusals keep mode and wide reference
		for (int i = 0; i < 3; i++)
		begin
			st = (i == 1) ? 11'h000 : 11'h020;
			op_enabled = (i != 2);
			mode_req(rcodes[i], 32'hdead_0000, 16'hbeef);
			check({starts[0], mode_reject_flag, mode_status_byte[6]}, 3'b011);
			check({mode_code, home_position_value}, {4'h7, 32'h1000_0007});
		end
		st = 11'h020;
		op_enabled = 1'b1;
		mode_req(7'h00, 32'h0, 16'h0);
		check({starts[0], mode_code}, 5'h07);
		poll();
		check({starts[0], mode_code}, 5'h07);
		mode_req(7'h04, 32'h0, 16'h0222);
		check({starts[0], mode_reject_flag, mode_code}, 6'h24);
		// state edges, precedence, zero value
		for (int i = 0; i < 11; i++)
		begin
			req_state = 8'h10;
			poll();
			req_state = scur[i];
			req_acc = 32'h0a00_0000 + i;
			req_dec = ~req_acc;
			poll();
			check(seen, sexp[i]);
			poll();
			check(seen, (scur[i] == 8'h00) ? 8'h01 : 8'h00);
			check({acceleration_ramp, deceleration_ramp}, {req_acc, ~req_acc});
		end
		end_sim();
	end
	// watchdog: the tests need about 200 cycles
	initial
	begin
		#500us;
		errors++;
		end_sim();
	end
endmodule : tb_drive_cyclic_command_decoder
